// ---- core/period_timer_regs.svh ----
// Register map, field positions, reset values and ratios of the period timer.
// Assumes an 8-bit register port with byte addresses as listed here.
`ifndef PERIOD_TIMER_REGS_SVH
`define PERIOD_TIMER_REGS_SVH

`define ADDR_W 8
`define DATA_W 8

`define OFS_IRQ_FLAGS 8'h0c
`define OFS_COUNTER 8'h11
`define OFS_CONTROL 8'h12
`define OFS_IRQ_ENABLES 8'h8c
`define OFS_LIMIT 8'h92

`define RST_IRQ_FLAGS 8'h00
`define RST_COUNTER 8'h00
`define RST_CONTROL 7'h00
`define RST_IRQ_ENABLES 8'h00
`define RST_LIMIT 8'hff
`define RD_IDLE 8'h00

`define CTRL_W 7
`define CTRL_PRE_LO 0
`define CTRL_PRE_HI 1
`define CTRL_RUN 2
`define CTRL_POST_LO 3
`define CTRL_POST_HI 6
`define MATCH_BIT 1

`define PRE_W 4
`define POST_W 4
`define PHASE_W 2
`define PHASE_LAST 2'h3
`define PRE_SEL_DIV1 2'h0
`define PRE_SEL_DIV4 2'h1
`define PRE_LAST_DIV1 4'h0
`define PRE_LAST_DIV4 4'h3
`define PRE_LAST_DIV16 4'hf

`endif

// ---- core/period_timer_pkg.sv ----
// Types shared by the period timer design.
// Assumes the register header sits beside this file.
`include "period_timer_regs.svh"

package period_timer_pkg;

    typedef struct packed {
        logic [`PHASE_W-1:0] phase;
        logic [`PRE_W-1:0] pre;
        logic [`DATA_W-1:0] count;
        logic [`DATA_W-1:0] limit;
        logic [`CTRL_W-1:0] ctrl;
        logic [`POST_W-1:0] post;
        logic flag;
        logic [`DATA_W-1:0] irq_en;
        logic match;
        logic irq;
        logic [`DATA_W-1:0] rdata;
    } state_s;

endpackage

// ---- core/period_timer.sv ----
// 8-bit period timer with prescaler, period limit and postscaler.
// Assumes clk_in is the oscillator clock and one reset covers every cause.
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps

module period_timer
    import period_timer_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [`DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [`DATA_W-1:0] rdata_out,
    output logic irq_out,
    output logic match_pulse_out,
    output logic [`DATA_W-1:0] timebase_out,
    output logic [`DATA_W-1:0] timebase_limit_out
);

    state_s state_reg;
    state_s state_next;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic wr_count;
        logic wr_ctrl;
        logic inst_tick;
        logic pre_tick;
        logic [`PRE_W-1:0] pre_last;
        logic set_flag;
        logic [`DATA_W-1:0] flags_view;
        logic [`DATA_W-1:0] ctrl_view;

        state_next = state_reg;
        pre_last = `PRE_LAST_DIV16;
        inst_tick = 1'b0;
        flags_view = '0;
        ctrl_view = '0;
        wr_count = wr_in && (addr_in == `OFS_COUNTER);
        wr_ctrl = wr_in && (addr_in == `OFS_CONTROL);
        set_flag = 1'b0;
        pre_tick = 1'b0;
        state_next.match = 1'b0;

        // Instruction clock: one tick every fourth rising oscillator edge
        inst_tick = (state_reg.phase == `PHASE_LAST);
        state_next.phase = state_reg.phase + 1'b1;

        unique case (state_reg.ctrl[`CTRL_PRE_HI:`CTRL_PRE_LO])
            `PRE_SEL_DIV1: pre_last = `PRE_LAST_DIV1;
            `PRE_SEL_DIV4: pre_last = `PRE_LAST_DIV4;
            default: pre_last = `PRE_LAST_DIV16;
        endcase

        if (state_reg.ctrl[`CTRL_RUN] && inst_tick) begin
            if (state_reg.pre >= pre_last) begin
                state_next.pre = '0;
                pre_tick = 1'b1;
            end else begin
                state_next.pre = state_reg.pre + 1'b1;
            end
        end

        // A control write holds the count still in its own cycle
        if (pre_tick && !wr_ctrl) begin
            if (state_reg.count == state_reg.limit) begin
                state_next.count = '0;
                state_next.match = 1'b1;
                // Postscaler ratio is the field value plus one
                if (state_reg.post ==
                    state_reg.ctrl[`CTRL_POST_HI:`CTRL_POST_LO]) begin
                    state_next.post = '0;
                    set_flag = 1'b1;
                end else begin
                    state_next.post = state_reg.post + 1'b1;
                end
            end else begin
                state_next.count = state_reg.count + 1'b1;
            end
        end

        // Software writes win over a same-cycle increment
        if (wr_count) begin
            state_next.count = wdata_in;
            state_next.pre = '0;
            state_next.post = '0;
        end
        if (wr_ctrl) begin
            state_next.ctrl = wdata_in[`CTRL_W-1:0];
            state_next.pre = '0;
            state_next.post = '0;
        end
        if (wr_in && (addr_in == `OFS_LIMIT)) begin
            state_next.limit = wdata_in;
        end
        if (wr_in && (addr_in == `OFS_IRQ_ENABLES)) begin
            state_next.irq_en = wdata_in;
        end
        // Writing zero clears the flag; a coincident postscaler rollover still sets it
        if (wr_in && (addr_in == `OFS_IRQ_FLAGS)) begin
            state_next.flag = wdata_in[`MATCH_BIT];
        end
        if (set_flag) begin
            state_next.flag = 1'b1;
        end

        state_next.irq = state_next.flag &&
            state_next.irq_en[`MATCH_BIT];

        flags_view = '0;
        flags_view[`MATCH_BIT] = state_reg.flag;
        ctrl_view = {1'b0, state_reg.ctrl};

        state_next.rdata = `RD_IDLE;
        if (rd_in) begin
            unique case (addr_in)
                `OFS_IRQ_FLAGS: state_next.rdata = flags_view;
                `OFS_COUNTER: state_next.rdata = state_reg.count;
                `OFS_CONTROL: state_next.rdata = ctrl_view;
                `OFS_IRQ_ENABLES: state_next.rdata = state_reg.irq_en;
                `OFS_LIMIT: state_next.rdata = state_reg.limit;
                default: state_next.rdata = `RD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg.phase <= '0;
            state_reg.pre <= '0;
            state_reg.count <= `RST_COUNTER;
            state_reg.limit <= `RST_LIMIT;
            state_reg.ctrl <= `RST_CONTROL;
            state_reg.post <= '0;
            state_reg.flag <= 1'b0;
            state_reg.irq_en <= `RST_IRQ_ENABLES;
            state_reg.match <= 1'b0;
            state_reg.irq <= 1'b0;
            state_reg.rdata <= `RD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata_out = state_reg.rdata;
    assign irq_out = state_reg.irq;
    assign match_pulse_out = state_reg.match;
    assign timebase_out = state_reg.count;
    assign timebase_limit_out = state_reg.limit;

endmodule

// ---- verif/period_timer_checker.sv ----
// Port-level assertions for the period timer.
// Bound to every period_timer instance; sees only its ports.
`timescale 1ns/100ps
module period_timer_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic irq_out,
    input wire logic match_pulse_out,
    input wire logic [7:0] timebase_out,
    input wire logic [7:0] timebase_limit_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_limit_write: assert property (wr_in && addr_in == 8'h92
        |=> timebase_limit_out == $past(wdata_in)) else $error("limit write");
    a_count_write: assert property (wr_in && addr_in == 8'h11
        |=> timebase_out == $past(wdata_in)) else $error("count write");
    a_ctrl_keeps: assert property (wr_in && addr_in == 8'h12
        |=> $stable(timebase_out)) else $error("count moved");
    a_match_wrap: assert property (match_pulse_out
        |-> timebase_out == 8'h00) else $error("match off zero");
    a_match_pulse: assert property (match_pulse_out
        |=> !match_pulse_out) else $error("match too long");
    a_irq_cause: assert property ($rose(irq_out)
        |-> match_pulse_out || $past(wr_in)) else $error("irq uncaused");
    a_irq_hold: assert property (irq_out && !wr_in
        |=> irq_out) else $error("irq dropped");
    a_ctrl_bit7: assert property (rd_in && addr_in == 8'h12
        |=> !rdata_out[7]) else $error("bit 7 set");
endmodule
bind period_timer period_timer_checker u_period_timer_checker (.*);

// ---- verif/period_timer_with_pre_post_scaler_bench.sv ----
// Self-checking bench for the period timer.
// Drives the register port directly; reads are checked from a queue.
`timescale 1ns/100ps
module period_timer_with_pre_post_scaler_bench;
    logic clk_in, rst_in, wr_in, rd_in, irq_out, match_pulse_out, rd_d;
    logic [7:0] addr_in, wdata_in, rdata_out, v, k;
    logic [7:0] exp_q[$];
    int num_errors = 0, n_compared = 0, seed, n;
    time t0;
    period_timer u_period_timer (.clk_in(clk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
        .match_pulse_out(match_pulse_out), .timebase_out(),
        .timebase_limit_out());
    initial begin
        clk_in = 0;
        forever #25 clk_in = ~clk_in;
    end
    task check(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge clk_in);
        addr_in <= a; wdata_in <= d; wr_in <= 1;
        @(posedge clk_in);
        wr_in <= 0;
    endtask
    task rd(input logic [7:0] a, e);
        @(posedge clk_in);
        addr_in <= a; rd_in <= 1; exp_q.push_back(e);
        @(posedge clk_in);
        rd_in <= 0;
    endtask
    task wait_m;
        int i;
        i = 0;
        @(negedge clk_in);
        while (match_pulse_out !== 1'b1 && i < 5000) begin
            i++;
            @(negedge clk_in);
        end
        if (i >= 5000) begin
            num_errors++;
            end_sim;
        end
    endtask
    always @(posedge clk_in) rd_d <= rd_in;
    always @(negedge clk_in) if (rd_d === 1'b1) check(rdata_out, exp_q.pop_front());
    initial begin
        seed = 32'h6ede;
        rst_in = 1; addr_in = 0; wdata_in = 0; wr_in = 0; rd_in = 0;
        repeat (6) @(posedge clk_in);
        rst_in <= 0;
        rd(8'h0c, 0); rd(8'h11, 0); rd(8'h12, 0); rd(8'h8c, 0);
        rd(8'h92, 8'hff); rd(8'h13, 0);
        $display("reset values done");
        v = $random(seed);
        wr(8'h92, v); rd(8'h92, v);
        wr(8'h12, 8'hfb); rd(8'h12, 8'h7b);
        wr(8'h11, 8'h05); repeat (20) @(posedge clk_in); rd(8'h11, 5);
        wr(8'h12, 8'h78); rd(8'h11, 8'h05);
        $display("register access done");
        wr(8'h92, 3);
        for (int p = 0; p < 4; p++) begin
            wr(8'h11, 0); wr(8'h12, 8'h04 | p);
            wait_m; t0 = $time; wait_m;
            check(($time - t0) / 50, p == 0 ? 16 : p == 1 ? 64 : 256);
        end
        $display("prescale done");
        wr(8'h8c, 8'h02); wr(8'h92, 0);
        for (int j = 0; j < 3; j++) begin
            k = j == 0 ? 0 : j == 1 ? $random(seed) & 15 : 15;
            wr(8'h12, 0); wr(8'h11, 0); wr(8'h0c, 0);
            wr(8'h12, {1'b0, k[3:0], 3'b100});
            n = 0;
            do begin wait_m; n++; end while (irq_out !== 1'b1 && n < 20);
            check(n, k + 1);
        end
        $display("postscale done");
        wr(8'h12, 0); rd(8'h0c, 8'h02);
        wr(8'h8c, 0); @(negedge clk_in); check(irq_out, 0);
        wr(8'h8c, 2); @(negedge clk_in); check(irq_out, 1);
        wr(8'h0c, 0); @(negedge clk_in); check(irq_out, 0);
        rd(8'h0c, 0);
        repeat (3) @(posedge clk_in);
        $display("interrupt done");
        end_sim;
    end
endmodule
